// file: acs_agc_cs.sv
/*
  Gain loop control and carrier sense decision with its two
  configuration registers and a status readback.
  Assumes samples, RSSI and sync strobes are synchronous to clk and that
  the target amplitude code comes from the neighbouring register.
*/
// What this block does
// [R1] priority bit selects which amplifier reduces first
// [R2] relative threshold: off, 6, 10, 14 dB
// [R3] absolute threshold signed dB offset from target
// [R4] absolute code 1000 disables absolute detect
// [R5] codes 1001..0111 give -7..+7 dB
// [R6] hysteresis code picks gain change dead zone
// [R7] settle 8/16/24/32 samples after gain change
// [R8] hold code 00 adjusts gain normally
// [R9] hold code 01 freezes after sync word
// [R10] hold code 10 freezes analog, digital adjusts
// [R11] hold code 11 freezes all, manual override
// [R12] average amplitude over 8/16/32/64 samples
// [R13] target code maps to 24..42 dB goal
// [R14] carrier sense when any enabled threshold met
`default_nettype none
module acs_agc_cs
  import acs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic filt_valid,
  input wire logic [7:0] filt_amp,
  input wire logic [7:0] rssi_db,
  input wire logic [2:0] target_amplitude,
  input wire logic sync_found,
  input wire logic rx_restart,
  input wire logic manual_load,
  input wire logic [2:0] manual_lna,
  input wire logic [2:0] manual_lna2,
  input wire logic [2:0] manual_dvga,
  output logic [2:0] lna_gain,
  output logic [2:0] lna2_gain,
  output logic [2:0] dvga_gain,
  output logic gain_changed,
  output logic gain_frozen,
  output logic carrier_sense
);
  import acs_pkg::*;

  typedef enum logic {ST_TRACK, ST_SETTLE} acs_state_t;

  logic [7:0] prio_thr_q;
  logic [7:0] loop_ctl_q;
  logic [7:0] rdata_q;
  logic [2:0] lna_q, lna_d;
  logic [2:0] lna2_q, lna2_d;
  logic [2:0] dvga_q, dvga_d;
  logic changed_q;
  logic sync_seen_q;
  logic [5:0] wait_q;
  logic [7:0] rssi_base_q;
  logic cs_q;
  acs_state_t state_q;

  acs_avg_if avg_bus ();

  // register decode
  wire wr_prio = reg_wr && (reg_addr == OFS_PRIO_THR);
  wire wr_loop = reg_wr && (reg_addr == OFS_LOOP_CTL);

  // field extraction
  wire order_lna_first = prio_thr_q[POS_ORDER];
  wire [1:0] rel_code = prio_thr_q[POS_REL +: 2];
  wire [3:0] abs_code = prio_thr_q[POS_ABS +: 4];
  wire [1:0] hyst_code = loop_ctl_q[POS_HYST +: 2];
  wire [1:0] wait_code = loop_ctl_q[POS_WAIT +: 2];
  wire [1:0] flen_code = loop_ctl_q[POS_FLEN +: 2];
  acs_hold_t hold_sel;
  assign hold_sel = acs_hold_t'(loop_ctl_q[POS_HOLD +: 2]);

  // [R13] target goal table
  wire [7:0] target_db = TARGET_DB[target_amplitude];

  // [R12] averaging length to the averager
  assign avg_bus.len_sel = flen_code;
  assign avg_bus.sample_valid = filt_valid;
  assign avg_bus.sample = filt_amp;
  // samples taken while settling are discarded
  assign avg_bus.restart = (state_q == ST_SETTLE) || rx_restart;

  acs_avg u_avg (
    .clk(clk),
    .arst_n(arst_n),
    .av(avg_bus)
  );

  // [R9] freeze once the sync word has been seen
  wire sync_hold = (hold_sel == HOLD_ON_SYNC) && sync_seen_q;
  // [R8] [R10] [R11] which gain stages may move
  wire analog_hold = sync_hold || (hold_sel == HOLD_ANALOG) ||
                     (hold_sel == HOLD_ALL);
  wire digital_hold = sync_hold || (hold_sel == HOLD_ALL);

  // [R6] dead zone from hysteresis level
  wire signed [9:0] err = $signed({2'b00, avg_bus.avg}) -
                          $signed({2'b00, target_db});
  wire signed [9:0] up_thr = $signed({2'b00, HYST_UP_DB[hyst_code]});
  wire signed [9:0] dn_thr = -$signed({2'b00, HYST_DN_DB[hyst_code]});
  wire judge = avg_bus.avg_valid && (state_q == ST_TRACK);
  wire too_high = judge && (err > up_thr);
  wire too_low = judge && (err < dn_thr);

  wire lna_dn_ok = lna_q != GAIN_MIN;
  wire lna2_dn_ok = lna2_q != GAIN_MIN;
  wire lna_up_ok = lna_q != GAIN_MAX;
  wire lna2_up_ok = lna2_q != GAIN_MAX;
  wire analog_dn_ok = !analog_hold && (lna_dn_ok || lna2_dn_ok);
  wire analog_up_ok = !analog_hold && (lna_up_ok || lna2_up_ok);
  wire dvga_dn_ok = !digital_hold && (dvga_q != GAIN_MIN);
  wire dvga_up_ok = !digital_hold && (dvga_q != GAIN_MAX);
  wire manual_take = manual_load && (hold_sel == HOLD_ALL);

  // analog stages move before the digital stage in both directions
  always_comb
  begin
    lna_d = lna_q;
    lna2_d = lna2_q;
    dvga_d = dvga_q;
    if (manual_take)
    begin
      // [R11] software override while fully frozen
      lna_d = manual_lna;
      lna2_d = manual_lna2;
      dvga_d = manual_dvga;
    end
    else if (too_high)
    begin
      if (analog_dn_ok)
      begin
        // [R1] reduction order by priority bit
        if (order_lna_first)
        begin
          if (lna_dn_ok)
            lna_d = lna_q - 3'h1;
          else
            lna2_d = lna2_q - 3'h1;
        end
        else
        begin
          if (lna2_dn_ok)
            lna2_d = lna2_q - 3'h1;
          else
            lna_d = lna_q - 3'h1;
        end
      end
      else if (dvga_dn_ok)
        dvga_d = dvga_q - 3'h1;
    end
    else if (too_low)
    begin
      if (analog_up_ok)
      begin
        // [R1] recovery undoes reduction in reverse
        if (order_lna_first)
        begin
          if (lna2_up_ok)
            lna2_d = lna2_q + 3'h1;
          else
            lna_d = lna_q + 3'h1;
        end
        else
        begin
          if (lna_up_ok)
            lna_d = lna_q + 3'h1;
          else
            lna2_d = lna2_q + 3'h1;
        end
      end
      else if (dvga_up_ok)
        dvga_d = dvga_q + 3'h1;
    end
  end

  wire step = (lna_d != lna_q) || (lna2_d != lna2_q) ||
              (dvga_d != dvga_q);
  // [R7] settle length in samples
  wire [5:0] wait_len = WAIT_STEP * (6'(wait_code) + 6'h01);
  wire settle_done = filt_valid && (wait_q == 6'h01);

  // [R3] [R5] signed offset added to the target
  wire signed [9:0] abs_level = $signed({2'b00, target_db}) +
                                10'($signed(abs_code));
  // [R4] most negative code turns absolute detect off
  wire abs_en = abs_code != ABS_OFF_CODE;
  wire abs_hit = abs_en && ($signed({2'b00, rssi_db}) > abs_level);
  // [R2] rise over the tracked floor
  wire rel_en = rel_code != REL_OFF_CODE;
  wire [7:0] rise = (rssi_db > rssi_base_q) ? rssi_db - rssi_base_q : 8'h00;
  wire rel_hit = rel_en && (rise >= REL_RISE_DB[rel_code]);

  wire [7:0] status = {cs_q, analog_hold, digital_hold,
                       state_q == ST_SETTLE, sync_seen_q, 3'h0};
  wire [7:0] rd_mux = (reg_addr == OFS_PRIO_THR) ? {1'b0, prio_thr_q[6:0]} :
                      (reg_addr == OFS_LOOP_CTL) ? loop_ctl_q :
                      (reg_addr == OFS_STATUS) ? status : 8'h00;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prio_thr_q <= RST_PRIO_THR;
      loop_ctl_q <= RST_LOOP_CTL;
      rdata_q <= 8'h00;
    end
    else
    begin
      if (wr_prio)
        prio_thr_q <= {1'b0, reg_wdata[6:0]};
      if (wr_loop)
        loop_ctl_q <= reg_wdata;
      rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lna_q <= RST_GAIN;
      lna2_q <= RST_GAIN;
      dvga_q <= RST_GAIN;
      changed_q <= 1'b0;
    end
    else
    begin
      lna_q <= lna_d;
      lna2_q <= lna2_d;
      dvga_q <= dvga_d;
      changed_q <= step;
    end
  end

  // [R7] wait after every automatic gain step
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_TRACK;
      wait_q <= 6'h00;
    end
    else
    begin
      unique case (state_q)
        ST_TRACK:
        begin
          if (step && !manual_take)
          begin
            state_q <= ST_SETTLE;
            wait_q <= wait_len;
          end
        end
        ST_SETTLE:
        begin
          if (settle_done)
            state_q <= ST_TRACK;
          if (filt_valid)
            wait_q <= wait_q - 6'h01;
        end
      endcase
    end
  end

  // [R9] sync seen flag, set wins over restart
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sync_seen_q <= 1'b0;
    else if (sync_found)
      sync_seen_q <= 1'b1;
    else if (rx_restart)
      sync_seen_q <= 1'b0;
  end

  // [R14] either enabled detector asserts carrier sense
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rssi_base_q <= RST_RSSI_BASE;
      cs_q <= 1'b0;
    end
    else
    begin
      if (rx_restart || (filt_valid && rssi_db < rssi_base_q))
        rssi_base_q <= rssi_db;
      cs_q <= abs_hit || rel_hit;
    end
  end

  assign reg_rdata = rdata_q;
  assign lna_gain = lna_q;
  assign lna2_gain = lna2_q;
  assign dvga_gain = dvga_q;
  assign gain_changed = changed_q;
  assign gain_frozen = analog_hold && digital_hold;
  assign carrier_sense = cs_q;

endmodule
`default_nettype wire

// file: acs_agc_cs_monitor.sv
/*
  Port checker for acs_agc_cs; shadows both config registers.
  Assumes it is bound to the top module.
*/
`default_nettype none
module acs_agc_cs_monitor
  import acs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] rssi_db,
  input wire logic [2:0] target_amplitude,
  input wire logic manual_load,
  input wire logic [2:0] lna_gain,
  input wire logic [2:0] lna2_gain,
  input wire logic [2:0] dvga_gain,
  input wire logic gain_changed,
  input wire logic gain_frozen,
  input wire logic carrier_sense
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] thr_q, ctl_q;
  wire logic [1:0] rel = thr_q[5:4];
  wire logic [3:0] ac = thr_q[3:0];
  wire logic [1:0] hold = ctl_q[3:2];
  wire logic [8:0] g = {lna_gain, lna2_gain, dvga_gain};
  // sign extension, wraps to the right level mod 1024
  wire logic [9:0] lvl = {2'h0, TARGET_DB[target_amplitude]}
    + {{6{ac[3]}}, ac};
  wire logic hit = {2'h0, rssi_db} > lvl;
  wire logic known = reg_addr == OFS_PRIO_THR
    || reg_addr == OFS_LOOP_CTL || reg_addr == OFS_STATUS;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      thr_q <= RST_PRIO_THR;
      ctl_q <= RST_LOOP_CTL;
    end
    else if (reg_wr && reg_addr == OFS_PRIO_THR)
      thr_q <= {1'b0, reg_wdata[6:0]};
    else if (reg_wr && reg_addr == OFS_LOOP_CTL)
      ctl_q <= reg_wdata;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_moved;
    !$stable(g);
  endsequence
  // flag register loads on the same edge as the gains
  property p_moved;
    s_moved |-> gain_changed;
  endproperty
  a_moved: assert property (p_moved)
    else $error("gain move without flag");
  property p_still;
    $stable(g) |-> !gain_changed;
  endproperty
  a_still: assert property (p_still)
    else $error("flag without gain move");
  property p_abs;
    rel == REL_OFF_CODE && ac != ABS_OFF_CODE
      |=> carrier_sense == $past(hit);
  endproperty
  a_abs: assert property (p_abs)
    else $error("absolute level decision wrong");
  property p_abs_off;
    rel == REL_OFF_CODE && ac == ABS_OFF_CODE |=> !carrier_sense;
  endproperty
  a_abs_off: assert property (p_abs_off)
    else $error("carrier sense with detectors off");
  property p_frozen;
    hold == 2'h3 |-> gain_frozen;
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("full hold not flagged");
  property p_free;
    hold == 2'h0 |-> !gain_frozen;
  endproperty
  a_free: assert property (p_free)
    else $error("frozen flag in normal mode");
  property p_hold_all;
    hold == 2'h3 && !manual_load && !reg_wr |=> $stable(g);
  endproperty
  a_hold_all: assert property (p_hold_all)
    else $error("gain moved under full hold");
  property p_hold_an;
    hold == 2'h2 && !reg_wr |=> $stable(g[8:3]);
  endproperty
  a_hold_an: assert property (p_hold_an)
    else $error("analog gain moved under hold");
  property p_rd_ctl;
    reg_addr == OFS_LOOP_CTL && !reg_wr |=> reg_rdata == $past(ctl_q);
  endproperty
  a_rd_ctl: assert property (p_rd_ctl)
    else $error("loop control readback wrong");
  property p_rd_none;
    !known |=> reg_rdata == 8'h00;
  endproperty
  a_rd_none: assert property (p_rd_none)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// file: acs_avg.sv
/*
  Block averager of channel filter amplitude over 8 to 64 samples.
  Assumes samples arrive as one-cycle strobes.
*/
`default_nettype none
module acs_avg
  import acs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  acs_avg_if.avg_end av
);

  logic [AVG_SUM_W-1:0] sum_q;
  logic [6:0] cnt_q;
  logic [7:0] avg_q;
  logic valid_q;

  wire [2:0] shift = 3'(av.len_sel) + 3'(AVG_BASE_LOG2);
  wire [6:0] len = 7'h01 << shift;
  wire last = av.sample_valid && (cnt_q == len - 7'h01);
  wire [AVG_SUM_W-1:0] sum_in = sum_q + AVG_SUM_W'(av.sample);
  wire [AVG_SUM_W-1:0] quot = sum_in >> shift;

  // block average keeps no sample memory; trades latency for area
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sum_q <= '0;
      cnt_q <= '0;
      avg_q <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      valid_q <= last && !av.restart;
      if (av.restart || last)
      begin
        sum_q <= '0;
        cnt_q <= '0;
      end
      else if (av.sample_valid)
      begin
        sum_q <= sum_in;
        cnt_q <= cnt_q + 7'h01;
      end
      if (last && !av.restart)
        avg_q <= quot[7:0];
    end
  end

  assign av.avg_valid = valid_q;
  assign av.avg = avg_q;

endmodule
`default_nettype wire

// file: acs_avg_if.sv
/*
  Carrier between the loop controller and its amplitude averager.
  Assumes both ends run on the same clock.
*/
`default_nettype none
interface acs_avg_if;
  logic sample_valid;
  logic [7:0] sample;
  logic [1:0] len_sel;
  logic restart;
  logic avg_valid;
  logic [7:0] avg;

  modport ctl (output sample_valid, output sample, output len_sel,
               output restart, input avg_valid, input avg);
  modport avg_end (input sample_valid, input sample, input len_sel,
                   input restart, output avg_valid, output avg);
endinterface
`default_nettype wire

// file: acs_pkg.sv
/*
  Shared constants for the gain loop and carrier sense block: register
  offsets, field positions, reset values and decode tables.
  Assumes a single 100 MHz clock domain.
*/
`default_nettype none
package acs_pkg;

  localparam int CLK_MHZ = 100;

  // register offsets
  localparam logic [5:0] OFS_PRIO_THR = 6'h1c;
  localparam logic [5:0] OFS_LOOP_CTL = 6'h1d;
  localparam logic [5:0] OFS_STATUS = 6'h3e;

  localparam logic [7:0] RST_PRIO_THR = 8'h40;
  localparam logic [7:0] RST_LOOP_CTL = 8'h91;

  // fields of the priority/threshold register
  localparam int POS_ORDER = 6;
  localparam int POS_REL = 4;
  localparam int POS_ABS = 0;
  // fields of the loop timing/freeze register
  localparam int POS_HYST = 6;
  localparam int POS_WAIT = 4;
  localparam int POS_HOLD = 2;
  localparam int POS_FLEN = 0;

  localparam logic [3:0] ABS_OFF_CODE = 4'h8;
  localparam logic [1:0] REL_OFF_CODE = 2'h0;

  typedef enum logic [1:0] {
    HOLD_NONE,
    HOLD_ON_SYNC,
    HOLD_ANALOG,
    HOLD_ALL
  } acs_hold_t;

  // relative rise in dB for codes 1..3 (index 0 unused)
  localparam logic [3:0][7:0] REL_RISE_DB = {8'h0e, 8'h0a, 8'h06, 8'h00};

  // target amplitude in dB, index is the 3-bit code
  localparam logic [7:0][7:0] TARGET_DB = {
    8'h2a, 8'h28, 8'h26, 8'h24, 8'h21, 8'h1e, 8'h1b, 8'h18
  };

  // dead zone: decrease when error above UP, increase when below -DN
  localparam logic [3:0][7:0] HYST_UP_DB = {8'h04, 8'h03, 8'h02, 8'h02};
  localparam logic [3:0][7:0] HYST_DN_DB = {8'h08, 8'h05, 8'h03, 8'h02};

  // settle wait is (code + 1) * WAIT_STEP samples
  localparam logic [5:0] WAIT_STEP = 6'h08;

  // averaging length is 2 ** (code + AVG_BASE_LOG2)
  localparam int AVG_BASE_LOG2 = 3;
  localparam int AVG_SUM_W = 14;

  localparam logic [2:0] GAIN_MAX = 3'h7;
  localparam logic [2:0] GAIN_MIN = 3'h0;
  localparam logic [2:0] RST_GAIN = 3'h7;
  localparam logic [7:0] RST_RSSI_BASE = 8'hff;

endpackage
`default_nettype wire

// file: test_acs_agc_cs.sv
/*
  Bench for acs_agc_cs: register access, carrier sense, gain steps.
  Assumes acs_pkg and the monitor are compiled first.
*/
`default_nettype none
module test_acs_agc_cs
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, arst_n = 0, reg_wr = 0, filt_valid = 0, sync_found = 0;
  logic rx_restart = 0, manual_load = 0, gain_changed, gain_frozen;
  logic carrier_sense;
  logic [5:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, filt_amp = '0, rssi_db = '0, reg_rdata;
  logic [2:0] target_amplitude = '0, manual_lna = '0, manual_lna2 = '0;
  logic [2:0] manual_dvga = '0, lna_gain, lna2_gain, dvga_gain;
  wire [8:0] g = {lna_gain, lna2_gain, dvga_gain};
  int num_errors = 0, samples_checked = 0;
  byte unsigned tdb[8] = '{8'h18, 8'h1b, 8'h1e, 8'h21,
    8'h24, 8'h26, 8'h28, 8'h2a};
  acs_agc_cs dut (.clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rdata, .filt_valid, .filt_amp, .rssi_db, .target_amplitude,
    .sync_found, .rx_restart, .manual_load, .manual_lna, .manual_lna2,
    .manual_dvga, .lna_gain, .lna2_gain, .dvga_gain, .gain_changed,
    .gain_frozen, .carrier_sense);
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic rst();
    tick(1);
    arst_n <= 1'b0;
    tick(20);
    arst_n <= 1'b1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    tick(1);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    tick(1);
    reg_addr <= a;
    tick(1);
    @(negedge clk);
    chk(reg_rdata, e);
  endtask
  task automatic cs_at(input logic [7:0] r, input logic e);
    tick(1);
    rssi_db <= r;
    tick(3);
    @(negedge clk);
    chk(carrier_sense, e);
  endtask
  task automatic feed(input int n, input logic [7:0] amp);
    repeat (n)
    begin
      tick(1);
      filt_valid <= 1'b1;
      filt_amp <= amp;
      tick(1);
      filt_valid <= 1'b0;
    end
    tick(4);
    @(negedge clk);
  endtask
  // sync always pulses; only hold code 01 may react to it
  task automatic gstep(input logic [7:0] t, c, amp, input logic [8:0] e);
    rst();
    wr(OFS_PRIO_THR, t);
    wr(OFS_LOOP_CTL, c);
    tick(1);
    sync_found <= 1'b1;
    tick(1);
    sync_found <= 1'b0;
    feed(8, amp);
    chk(g, e);
  endtask
  initial
  begin
    rst();
    rc(OFS_PRIO_THR, 8'h40);
    rc(OFS_LOOP_CTL, 8'h91);
    rc(6'h05, 8'h00);
    wr(OFS_PRIO_THR, 8'hff);
    rc(OFS_PRIO_THR, 8'h7f);
    for (int c = -7; c < 8; c++)
    begin
      wr(OFS_PRIO_THR, {4'h4, 4'(c)});
      target_amplitude <= 3'(c);
      cs_at(8'(tdb[3'(c)] + c), 1'b0);
      cs_at(8'(tdb[3'(c)] + c + 1), 1'b1);
    end
    wr(OFS_PRIO_THR, 8'h48);
    cs_at(8'hfe, 1'b0);
    for (int r = 1; r < 4; r++)
    begin
      wr(OFS_PRIO_THR, {2'h1, 2'(r), 4'h8});
      rssi_db <= 8'h14;
      tick(1);
      rx_restart <= 1'b1;
      tick(1);
      rx_restart <= 1'b0;
      cs_at(8'(8'h15 + 4 * r), 1'b0);
      cs_at(8'(8'h16 + 4 * r), 1'b1);
    end
    tick(1);
    target_amplitude <= 3'h0;
    gstep(8'h48, 8'hc0, 8'h1c, {3'h7, 3'h7, 3'h7});
    gstep(8'h48, 8'h00, 8'h1c, {3'h6, 3'h7, 3'h7});
    feed(15, 8'h28);
    chk(g, {3'h6, 3'h7, 3'h7});
    feed(1, 8'h28);
    chk(g, {3'h5, 3'h7, 3'h7});
    gstep(8'h08, 8'h10, 8'h28, {3'h7, 3'h6, 3'h7});
    feed(23, 8'h28);
    chk(g, {3'h7, 3'h6, 3'h7});
    feed(1, 8'h28);
    chk(g, {3'h7, 3'h5, 3'h7});
    gstep(8'h48, 8'h03, 8'h28, {3'h7, 3'h7, 3'h7});
    feed(55, 8'h28);
    chk(g, {3'h7, 3'h7, 3'h7});
    feed(1, 8'h28);
    chk(g, {3'h6, 3'h7, 3'h7});
    gstep(8'h48, 8'h04, 8'h28, {3'h7, 3'h7, 3'h7});
    gstep(8'h48, 8'h08, 8'h28, {3'h7, 3'h7, 3'h6});
    gstep(8'h48, 8'h0c, 8'h28, {3'h7, 3'h7, 3'h7});
    chk(gain_frozen, 1'b1);
    tick(1);
    manual_lna <= 3'h2;
    manual_lna2 <= 3'h3;
    manual_dvga <= 3'h4;
    manual_load <= 1'b1;
    tick(1);
    manual_load <= 1'b0;
    tick(2);
    @(negedge clk);
    chk(g, {3'h2, 3'h3, 3'h4});
    rc(OFS_STATUS, 8'h68);
    // low hysteresis: -3 dB stays in the dead zone, -4 dB raises gain
    wr(OFS_LOOP_CTL, 8'h40);
    feed(8, 8'h15);
    chk(g, {3'h2, 3'h3, 3'h4});
    feed(8, 8'h14);
    chk(g, {3'h2, 3'h4, 3'h4});
    conclude();
  end
  initial
  begin
    #100us;
    num_errors++;
    conclude();
  end
endmodule
bind acs_agc_cs acs_agc_cs_monitor mon (.clk, .arst_n, .reg_addr,
  .reg_wr, .reg_wdata, .reg_rdata, .rssi_db, .target_amplitude,
  .manual_load, .lna_gain, .lna2_gain, .dvga_gain, .gain_changed,
  .gain_frozen, .carrier_sense);
`default_nettype wire
